// File: shared/port_cfg_defines.svh
// Functional notes
// - Pull acts only on input pins
// - Pull enables reset cleared
// - Polarity one pulls down, zero pulls up
// - Polarity also picks interrupt edge
// - Slew bit disables input buffer
// - Stop forces slew off, 300 ns resume
// - Routed peripheral inputs keep buffer enabled, except while motor control function is set
// - Routing bit 2 moves timer1 channel2
// - Routing bit 3 moves timer1 channel3
// - Reserved locations read zero, ignore writes
// - Registers writable at any time
// - No pull on push-pull output
// - Data write drives only gpio outputs
// - Data read picks pin or latch
// - Input register returns synchronized pin
// - Peripheral pins still use direction readback
// - Readback settles within two cycles
// - Pins usable as gpio or peripheral
`ifndef PORT_CFG_DEFINES_SVH
`define PORT_CFG_DEFINES_SVH
// ****************************************
// Offsets
// ****************************************
`define OFS_DATA      8'h00
`define OFS_INPUT     8'h04
`define OFS_DIR       8'h08
`define OFS_PULL_EN   8'h0c
`define OFS_PULL_POL  8'h10
`define OFS_SLEW      8'h14
`define OFS_ROUTE     8'h18
`define OFS_LAST      8'h1c
// ****************************************
// Fields and reset values
// ****************************************
`define ROUTE_CH2_BIT 2
`define ROUTE_CH3_BIT 3
`define ROUTE_MASK    8'h0c
`define RST_REG8      8'h00
// ****************************************
// Timing
// ****************************************
`define SLEW_SETTLE_NS 300
`define CLK_PERIOD_NS  5
`define SLEW_SETTLE_CYC ((`SLEW_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: shared/port_cfg_pkg.sv
package port_cfg_pkg;
   typedef struct packed {
      logic [7:0] data;
      logic [7:0] dir;
      logic [7:0] pull_en;
      logic [7:0] pull_pol;
      logic [7:0] slew;
      logic [7:0] route;
   } cfg_regs_t;

   typedef struct packed {
      logic [7:0] out_val;
      logic [7:0] out_en_n;
      logic [7:0] pull_up;
      logic [7:0] pull_down;
      logic [7:0] inbuf_en;
      logic [7:0] slew_on;
      logic [7:0] irq_rise;
   } pad_ctrl_t;

   typedef enum logic [1:0] {
      W_IDLE = 2'b00,
      W_RESP = 2'b01
   } wr_state_t;

   typedef struct packed {
      cfg_regs_t  regs;
      logic [7:0] sync1;
      logic [7:0] sync2;
      logic [7:0] slew_eff;
      logic [7:0] settle_cnt;
      logic       stop_prev;
      logic       slew_nz_prev;
      pad_ctrl_t  pad;
      logic       awv;
      logic [7:0] awa;
      logic       wv;
      logic [31:0] wd;
      logic [3:0] ws;
      wr_state_t  wst;
      logic       bvalid;
      logic       arready;
      logic       rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [1:0] bresp;
      logic [1:0] route_out;
   } state_t;
endpackage : port_cfg_pkg

// File: logic/port_pin_config_and_routing.sv
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "port_cfg_defines.svh"
module port_pin_config_and_routing #(
   parameter int W = 8
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        clk_en,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [7:0]  pad_in,
   input  wire logic [7:0]  periph_ctrl,
   input  wire logic [7:0]  periph_out,
   input  wire logic [7:0]  periph_oe,
   input  wire logic [7:0]  periph_inbuf_keep,
   input  wire logic        motor_control_function,
   input  wire logic        stop_mode,
   output port_cfg_pkg::pad_ctrl_t pad,
   output logic             timer1_channel2_on_portm_pin2,
   output logic             timer1_channel3_on_portm_pin3,
   output logic             slew_settled
);
   port_cfg_pkg::state_t s_q;
   port_cfg_pkg::state_t s_d;

   localparam int SETTLE = `SLEW_SETTLE_CYC;

   function automatic logic [7:0] merge8(input logic [7:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] ws);
      merge8 = ws[0] ? wd[7:0] : old;
   endfunction : merge8

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a < `OFS_LAST) && (a[1:0] == 2'b00);
   endfunction : mapped

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      logic [7:0] pin_rd;
      logic [7:0] drv_dir;
      logic       slew_nz;
      pin_rd  = 8'h00;
      drv_dir = 8'h00;
      slew_nz = 1'b0;
      s_d = s_q;
      // Two-stage synchroniser on pad inputs
      s_d.sync1 = pad_in;
      s_d.sync2 = s_q.sync1;
      // Data read chooses pin or latch by direction even under peripheral
      pin_rd = (s_q.regs.dir & s_q.regs.data)
               | (~s_q.regs.dir & s_q.sync2);

      // Slew: forced off in stop, settle delay on nonzero change or wake
      slew_nz = |s_q.regs.slew;
      s_d.stop_prev    = stop_mode;
      s_d.slew_nz_prev = slew_nz;
      if (stop_mode) begin
         s_d.slew_eff   = 8'h00;
         s_d.settle_cnt = 8'(SETTLE);
      end else if ((s_q.stop_prev && !stop_mode)
                   || (slew_nz != s_q.slew_nz_prev)) begin
         s_d.settle_cnt = 8'(SETTLE);
      end else if (s_q.settle_cnt != 8'h00) begin
         s_d.settle_cnt = s_q.settle_cnt - 8'h01;
      end else begin
         s_d.slew_eff = s_q.regs.slew;
      end

      // Pad control, peripheral overrides direction for driving
      drv_dir = (periph_ctrl & periph_oe)
                | (~periph_ctrl & s_q.regs.dir);
      s_d.pad.out_val  = (periph_ctrl & periph_out)
                         | (~periph_ctrl & s_q.regs.data);
      s_d.pad.out_en_n = ~drv_dir;
      s_d.pad.pull_up  = s_q.regs.pull_en & ~drv_dir
                         & ~s_q.regs.pull_pol;
      s_d.pad.pull_down = s_q.regs.pull_en & ~drv_dir
                          & s_q.regs.pull_pol;
      s_d.pad.slew_on  = s_d.slew_eff;
      s_d.pad.inbuf_en = ~s_d.slew_eff
                         | (motor_control_function ? 8'h00
                            : periph_inbuf_keep);
      // Pull-down idles low, so its active edge is the rising one
      s_d.pad.irq_rise = s_q.regs.pull_pol;
      s_d.route_out = {s_q.regs.route[`ROUTE_CH3_BIT],
                       s_q.regs.route[`ROUTE_CH2_BIT]};

      // ****************************************
      // AXI write
      // ****************************************
      if (s_q.wst == port_cfg_pkg::W_IDLE) begin
         if (!s_q.awv && s_axi_awvalid) begin
            s_d.awv = 1'b1;
            s_d.awa = s_axi_awaddr;
         end
         if (!s_q.wv && s_axi_wvalid) begin
            s_d.wv = 1'b1;
            s_d.wd = s_axi_wdata;
            s_d.ws = s_axi_wstrb;
         end
         if (s_q.awv && s_q.wv) begin
            s_d.bresp = mapped(s_q.awa) ? 2'b00 : 2'b10;
            unique case (s_q.awa)
               `OFS_DATA:
                  s_d.regs.data = merge8(s_q.regs.data, s_q.wd, s_q.ws);
               `OFS_DIR:
                  s_d.regs.dir = merge8(s_q.regs.dir, s_q.wd, s_q.ws);
               `OFS_PULL_EN:
                  s_d.regs.pull_en = merge8(s_q.regs.pull_en, s_q.wd,
                                            s_q.ws);
               `OFS_PULL_POL:
                  s_d.regs.pull_pol = merge8(s_q.regs.pull_pol, s_q.wd,
                                             s_q.ws);
               `OFS_SLEW:
                  s_d.regs.slew = merge8(s_q.regs.slew, s_q.wd, s_q.ws);
               `OFS_ROUTE:
                  s_d.regs.route = merge8(s_q.regs.route, s_q.wd, s_q.ws)
                                   & `ROUTE_MASK;
               default: ;
            endcase
            s_d.awv = 1'b0;
            s_d.wv = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.wst = port_cfg_pkg::W_RESP;
         end
      end else begin
         if (s_axi_bready) begin
            s_d.bvalid = 1'b0;
            s_d.wst = port_cfg_pkg::W_IDLE;
         end
      end

      // ****************************************
      // AXI read
      // ****************************************
      s_d.arready = 1'b0;
      if (s_q.rvalid) begin
         if (s_axi_rready) s_d.rvalid = 1'b0;
      end else if (s_axi_arvalid && !s_q.arready) begin
         s_d.arready = 1'b1;
         s_d.rvalid = 1'b1;
         s_d.rresp = mapped(s_axi_araddr) ? 2'b00 : 2'b10;
         unique case (s_axi_araddr)
            `OFS_DATA:     s_d.rdata = {24'h000000, pin_rd};
            `OFS_INPUT:    s_d.rdata = {24'h000000, s_q.sync2};
            `OFS_DIR:      s_d.rdata = {24'h000000, s_q.regs.dir};
            `OFS_PULL_EN:  s_d.rdata = {24'h000000, s_q.regs.pull_en};
            `OFS_PULL_POL: s_d.rdata = {24'h000000, s_q.regs.pull_pol};
            `OFS_SLEW:     s_d.rdata = {24'h000000, s_q.regs.slew};
            `OFS_ROUTE:    s_d.rdata = {24'h000000, s_q.regs.route};
            default:       s_d.rdata = 32'h00000000;
         endcase
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   // Outputs from flops; awready, wready and slew_settled are decoded from state flops
   assign s_axi_awready = (s_q.wst == port_cfg_pkg::W_IDLE) && !s_q.awv;
   assign s_axi_wready  = (s_q.wst == port_cfg_pkg::W_IDLE) && !s_q.wv;
   assign s_axi_bvalid  = s_q.bvalid;
   assign s_axi_bresp   = s_q.bresp;
   assign s_axi_arready = s_q.arready;
   assign s_axi_rvalid  = s_q.rvalid;
   assign s_axi_rdata   = s_q.rdata;
   assign s_axi_rresp   = s_q.rresp;
   assign pad           = s_q.pad;
   assign timer1_channel2_on_portm_pin2 = s_q.route_out[0];
   assign timer1_channel3_on_portm_pin3 = s_q.route_out[1];
   assign slew_settled  = (s_q.settle_cnt == 8'h00);

   // ****************************************
   // Assertions
   // ****************************************
   a_pull_out_off: assert property (@(posedge aclk) disable iff (!aresetn)
      (~pad.out_en_n & (pad.pull_up | pad.pull_down)) == 8'h00)
      else $error("pull active on driven pins");
   a_reset_pull_clear: assert property (@(posedge aclk)
      !aresetn |=> s_q.regs.pull_en == 8'h00)
      else $error("pull enable not cleared");
   a_pull_exclusive: assert property (@(posedge aclk) disable iff (!aresetn)
      (pad.pull_up & pad.pull_down) == 8'h00)
      else $error("pull up and down together");
   a_irq_edge_pol: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && $stable(s_q.regs.pull_pol) |=> pad.irq_rise
      == $past(s_q.regs.pull_pol))
      else $error("edge polarity mismatch");
   a_stop_slew_off: assert property (@(posedge aclk) disable iff (!aresetn)
      stop_mode && clk_en |=> ##1 pad.slew_on == 8'h00 || !clk_en)
      else $error("slew on during stop");
   a_input_sync: assert property (@(posedge aclk) disable iff (!aresetn)
      (aresetn && clk_en) [*3] |-> s_q.sync2 == $past(pad_in, 2))
      else $error("input sync latency wrong");
   a_route_unused: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_q.regs.route & ~`ROUTE_MASK) == 8'h00)
      else $error("routing unused bits set");
   a_bad_read_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
      else $error("reserved read not zero");
endmodule : port_pin_config_and_routing

// File: tb/port_pin_config_and_routing_test.sv
`timescale 1ns/1ps
`include "port_cfg_defines.svh"
module port_pin_config_and_routing_test;
   logic                   aclk, aresetn, awvalid, wvalid, bready;
   logic                   arvalid, rready, awready, wready, bvalid;
   logic                   arready, rvalid, stop_mode, mcf, ch2, ch3, settled;
   logic [7:0]             awaddr, araddr, pad_in, pctrl, keep;
   logic [31:0]            wdata, rdata;
   logic [1:0]             bresp, rresp, resp;
   logic [31:0]            rd;
   port_cfg_pkg::pad_ctrl_t pad;
   int                     n_mismatch, comparisons, i;
   // ****************************************
   // Clock, reset and device
   // ****************************************
   initial begin
      aclk = 0;
      forever #2.5 aclk = ~aclk;
   end
   port_pin_config_and_routing u_port_pin_config_and_routing (
      .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .pad_in(pad_in), .periph_ctrl(pctrl),
      .periph_out(8'h00), .periph_oe(8'h00), .periph_inbuf_keep(keep),
      .motor_control_function(mcf), .stop_mode(stop_mode), .pad(pad),
      .timer1_channel2_on_portm_pin2(ch2),
      .timer1_channel3_on_portm_pin3(ch3), .slew_settled(settled));
   // ****************************************
   // Tasks
   // ****************************************
   task automatic final_report;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : final_report
   task automatic hang;
      n_mismatch++;
      $display("[ERR] handshake wait ran out");
      final_report();
   endtask : hang
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (e !== g) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask : cyc
   // Handshakes are judged on settled values before the edge that takes them
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic aw_hs, w_hs, b_hs;
      b_hs = 1'b0;
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      for (i = 0; i < 200 && !b_hs; i++) begin
         @(negedge aclk);
         aw_hs = awvalid && (awready === 1'b1);
         w_hs = wvalid && (wready === 1'b1);
         b_hs = (bvalid === 1'b1);
         if (b_hs) resp = bresp;
         @(posedge aclk);
         if (aw_hs) awvalid <= 0;
         if (w_hs) wvalid <= 0;
      end
      if (!b_hs) hang();
      bready <= 0;
      @(posedge aclk);
   endtask : wr
   task automatic rdr(input logic [7:0] a);
      logic ar_hs, r_hs;
      r_hs = 1'b0;
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      for (i = 0; i < 200 && !r_hs; i++) begin
         @(negedge aclk);
         ar_hs = arvalid && (arready === 1'b1);
         r_hs = (rvalid === 1'b1);
         if (r_hs) begin
            rd = rdata;
            resp = rresp;
         end
         @(posedge aclk);
         if (ar_hs && !r_hs) arvalid <= 0;
      end
      if (!r_hs) hang();
      arvalid <= 0;
      rready <= 0;
      @(posedge aclk);
   endtask : rdr
   task automatic wait_settle;
      cyc(3);
      for (i = 0; i < 200 && settled !== 1'b1; i++) @(posedge aclk);
      if (i == 200) hang();
      cyc(3);
   endtask : wait_settle
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, stop_mode, mcf} = '0;
      {awaddr, araddr, wdata, pctrl, keep} = '0;
      pad_in = 8'h3c;
      aresetn = 0;
      cyc(16);
      aresetn <= 1;
      cyc(2);
      rdr(`OFS_PULL_EN); chk("pull_en rst", 0, rd);
      rdr(`OFS_ROUTE); chk("route rst", 0, rd);
      chk("route outs rst", 0, {ch2, ch3});
      wr(`OFS_PULL_EN, 8'hff);
      wr(`OFS_PULL_POL, 8'h0f);
      cyc(3);
      chk("pull_up in", 8'hf0, pad.pull_up);
      chk("pull_down in", 8'h0f, pad.pull_down);
      chk("irq_rise", 8'h0f, pad.irq_rise);
      wr(`OFS_PULL_POL, 8'h3c);
      cyc(3);
      chk("irq_rise 2", 8'h3c, pad.irq_rise);
      wr(`OFS_PULL_POL, 8'h0f);
      cyc(3);
      cyc(2);
      rdr(`OFS_DATA); chk("data as input", 8'h3c, rd);
      rdr(`OFS_INPUT); chk("input reg", 8'h3c, rd);
      // Data stored first so outputs come up with no extra edge
      wr(`OFS_DATA, 8'ha5);
      chk("data no drive", 8'hff, pad.out_en_n);
      wr(`OFS_DIR, 8'hff);
      wr(`OFS_PULL_POL, 8'h55);
      cyc(3);
      chk("pull_up out", 0, pad.pull_up);
      chk("pull_down out", 0, pad.pull_down);
      chk("out_en_n", 0, pad.out_en_n);
      chk("out_val", 8'ha5, pad.out_val);
      rdr(`OFS_DATA); chk("data as output", 8'ha5, rd);
      rdr(`OFS_PULL_POL); chk("pol written", 8'h55, rd);
      rdr(`OFS_INPUT); chk("input when out", 8'h3c, rd);
      pctrl <= 8'hff;
      wr(`OFS_DIR, 8'h00);
      cyc(2);
      rdr(`OFS_DATA); chk("periph readback", 8'h3c, rd);
      pad_in <= 8'hc3;
      cyc(3);
      rdr(`OFS_DATA); chk("pin follows", 8'hc3, rd);
      pctrl <= 8'h00;
      keep <= 8'h01;
      wr(`OFS_SLEW, 8'hff);
      wait_settle();
      chk("slew_on", 8'hff, pad.slew_on);
      chk("inbuf keep", 8'h01, pad.inbuf_en);
      stop_mode <= 1;
      cyc(3);
      chk("slew stop", 0, pad.slew_on);
      stop_mode <= 0;
      cyc(3);
      chk("slew resume wait", 0, pad.slew_on);
      wait_settle();
      chk("slew resumed", 8'hff, pad.slew_on);
      mcf <= 1;
      cyc(3);
      chk("inbuf mc on", 0, pad.inbuf_en);
      wr(`OFS_SLEW, 8'h00);
      wait_settle();
      chk("inbuf on", 8'hff, pad.inbuf_en);
      wr(`OFS_ROUTE, 8'hff);
      rdr(`OFS_ROUTE); chk("route mask", 8'h0c, rd);
      chk("route both", 2'b11, {ch2, ch3});
      wr(`OFS_ROUTE, 8'h04);
      cyc(2);
      chk("route ch2", 2'b10, {ch2, ch3});
      wr(`OFS_ROUTE, 8'h08);
      cyc(2);
      chk("route ch3", 2'b01, {ch2, ch3});
      wr(`OFS_LAST, 8'hff);
      chk("reserved wr resp", 2'b10, resp);
      rdr(`OFS_LAST); chk("reserved rd", 0, rd);
      chk("reserved rd resp", 2'b10, resp);
      rdr(`OFS_PULL_EN); chk("pull_en kept", 8'hff, rd);
      aresetn <= 0;
      cyc(2);
      aresetn <= 1;
      cyc(2);
      rdr(`OFS_SLEW); chk("slew rst", 0, rd);
      rdr(`OFS_PULL_EN); chk("pull_en rst2", 0, rd);
      final_report();
   end
endmodule : port_pin_config_and_routing_test
